// ### design/csf_defs.svh
// Bit positions, widths and reset values of the status flag unit
`ifndef CSF_DEFS_SVH
`define CSF_DEFS_SVH
`define CSF_BIT_C 0
`define CSF_BIT_AC 1
`define CSF_BIT_Z 2
`define CSF_BIT_OV 3
`define CSF_BIT_PDF 4
`define CSF_BIT_TO 5
`define CSF_BIT_CZ 6
`define CSF_BIT_SC 7
`define CSF_DATA_W 8
`define CSF_NIB_W 4
`define CSF_ARITH_RST 6'h00
`define CSF_SYS_RST 1'b0
`define CSF_ZERO_BYTE 8'h00
`endif

// ### design/csf_pkg.sv
// Types shared by the status flag unit
package csf_pkg;
	typedef enum logic [2:0] {
		CSF_OP_NONE,
		CSF_OP_ADD,
		CSF_OP_SUB,
		CSF_OP_SBC,
		CSF_OP_LOGIC,
		CSF_OP_RLC,
		CSF_OP_RRC
	} csf_op_t;

	typedef struct packed {
		logic valid;
		csf_op_t op;
		logic [7:0] a;
		logic [7:0] b;
		logic carry_in;
	} csf_alu_req_t;

	typedef struct packed {
		logic [7:0] result;
		logic c;
		logic ac;
		logic z;
		logic ov;
		logic sc;
		logic c_upd;
		logic arith_upd;
		logic z_upd;
	} csf_alu_res_t;
endpackage

// ### design/csf_alu_flags.sv
// Combinational ALU result and flag generation
`timescale 1ns/10ps
`include "csf_defs.svh"
module csf_alu_flags
(
	input wire csf_pkg::csf_alu_req_t req, // Operation request
	output csf_pkg::csf_alu_res_t res // Result and flags
);
	import csf_pkg::*;

	localparam int W = `CSF_DATA_W;
	localparam int N = `CSF_NIB_W;

	logic [W:0] sum;
	logic [N:0] nib;
	logic [W-1:0] low7;
	logic [W-1:0] b_eff;
	logic cin_eff;
	logic carry_msb;

	always_comb
	begin
		b_eff = req.b;
		cin_eff = 1'b0;
		res = '0;
		// Subtraction is add of complement, so carry out means no borrow
		unique case (req.op)
			CSF_OP_ADD:
			begin
				b_eff = req.b;
				cin_eff = req.carry_in;
			end
			CSF_OP_SUB:
			begin
				b_eff = ~req.b;
				cin_eff = 1'b1;
			end
			CSF_OP_SBC:
			begin
				b_eff = ~req.b;
				cin_eff = req.carry_in;
			end
			default:
			begin
				b_eff = req.b;
				cin_eff = 1'b0;
			end
		endcase
		sum = {1'b0, req.a} + {1'b0, b_eff} + {{W{1'b0}}, cin_eff};
		nib = {1'b0, req.a[N-1:0]} + {1'b0, b_eff[N-1:0]} + {{N{1'b0}}, cin_eff};
		low7 = {1'b0, req.a[W-2:0]} + {1'b0, b_eff[W-2:0]} + {{(W-1){1'b0}}, cin_eff};
		carry_msb = low7[W-1];
		unique case (req.op)
			CSF_OP_ADD, CSF_OP_SUB, CSF_OP_SBC:
			begin
				res.result = sum[W-1:0];
				res.c = sum[W];
				res.ac = nib[N];
				res.ov = carry_msb ^ sum[W];
				res.c_upd = 1'b1;
				res.arith_upd = 1'b1;
				res.z_upd = 1'b1;
			end
			CSF_OP_LOGIC:
			begin
				res.result = req.a;
				res.z_upd = 1'b1;
			end
			CSF_OP_RLC:
			begin
				res.result = {req.a[W-2:0], req.carry_in};
				res.c = req.a[W-1];
				res.c_upd = 1'b1;
			end
			CSF_OP_RRC:
			begin
				res.result = {req.carry_in, req.a[W-1:1]};
				res.c = req.a[0];
				res.c_upd = 1'b1;
			end
			default:
			begin
				res.result = req.a;
			end
		endcase
		res.z = (res.result == `CSF_ZERO_BYTE);
		res.sc = res.ov ^ res.result[W-1];
	end
endmodule

// ### design/csf_sys_flags.sv
// Watchdog time-out and power-down flags, hardware events only
`timescale 1ns/10ps
`include "csf_defs.svh"
module csf_sys_flags
(
	input wire logic sys_clk, // Core clock
	input wire logic reset, // Power-on reset
	input wire logic wdt_kick, // Clear-watchdog instruction executed
	input wire logic halt_exec, // Halt instruction executed
	input wire logic wdt_expire, // Watchdog expiry pulse
	output logic watchdog_expired_flag_r, // Time-out flag
	output logic powerdown_flag_r // Power-down flag
);
	import csf_pkg::*;

	// Software writes never reach these flops
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			powerdown_flag_r <= `CSF_SYS_RST;
		else if (halt_exec)
			powerdown_flag_r <= 1'b1;
		else if (wdt_kick)
			powerdown_flag_r <= 1'b0;
	end

	// Expiry wins over a clear in the same cycle so the event is not lost
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			watchdog_expired_flag_r <= `CSF_SYS_RST;
		else if (wdt_expire)
			watchdog_expired_flag_r <= 1'b1;
		else if (wdt_kick || halt_exec)
			watchdog_expired_flag_r <= 1'b0;
	end

	property p_pdf_halt;
		@(posedge sys_clk) disable iff (reset)
		halt_exec |=> powerdown_flag_r;
	endproperty
	a_pdf_halt: assert property (p_pdf_halt) else $error("power-down flag not set by halt");

	property p_pdf_kick;
		@(posedge sys_clk) disable iff (reset)
		(wdt_kick && !halt_exec) |=> !powerdown_flag_r;
	endproperty
	a_pdf_kick: assert property (p_pdf_kick) else $error("power-down flag not cleared by kick");

	property p_to_set;
		@(posedge sys_clk) disable iff (reset)
		wdt_expire |=> watchdog_expired_flag_r;
	endproperty
	a_to_set: assert property (p_to_set) else $error("time-out flag not set on expiry");

	property p_to_clr;
		@(posedge sys_clk) disable iff (reset)
		(!wdt_expire && (wdt_kick || halt_exec)) |=> !watchdog_expired_flag_r;
	endproperty
	a_to_clr: assert property (p_to_clr) else $error("time-out flag not cleared");

	property p_to_hold;
		@(posedge sys_clk) disable iff (reset)
		(!wdt_expire && !wdt_kick && !halt_exec) |=> $stable(watchdog_expired_flag_r);
	endproperty
	a_to_hold: assert property (p_to_hold) else $error("time-out flag changed without event");
endmodule

// ### design/csf_status_unit.sv
// Status register of the core: arithmetic flags and system flags
// Overview of operation
// - Carry set on add carry-out or subtract without borrow, else cleared.
// - Rotate-through-carry instructions shift the carry in and out of the byte.
// - Half carry set on low-nibble carry or no nibble borrow, else cleared.
// - Zero flag set when arithmetic or logical result is zero.
// - Overflow set when carry into MSB differs from carry out.
// - Signed-compare flag is overflow XOR result MSB.
// - Plain subtract makes chained-zero equal to zero flag.
// - Subtract-with-borrow ANDs previous chained-zero with the new zero flag.
// - All other instructions leave chained-zero unchanged.
// - Software writes change arithmetic flags only, never time-out or power-down.
// - Power-down cleared by power-up or kick, set by halt.
// - Time-out cleared by power-up, kick or halt, set on watchdog expiry.
// - Status is not saved automatically on interrupt entry or call.
`timescale 1ns/10ps
`include "csf_defs.svh"
module csf_status_unit
(
	input wire logic sys_clk, // Core clock, 250 MHz
	input wire logic reset, // Synchronous power-on reset
	input wire csf_pkg::csf_alu_req_t alu_req, // Instruction operation
	input wire logic sw_wr, // Software write to status register
	input wire logic [7:0] sw_wdata, // Software write data
	input wire logic wdt_kick, // Clear-watchdog instruction
	input wire logic halt_exec, // Halt instruction
	input wire logic wdt_expire, // Watchdog timer expiry
	output logic [7:0] alu_result_r, // Registered ALU result
	output logic [7:0] arith_status_flags // Status register read value
);
	import csf_pkg::*;

	csf_alu_res_t res;
	logic carry_flag_r;
	logic half_carry_flag_r;
	logic zero_flag_r;
	logic overflow_flag_r;
	logic signed_compare_flag_r;
	logic chained_zero_flag_r;
	logic watchdog_expired_flag_r;
	logic powerdown_flag_r;
	logic chained_zero_flag_nxt;
	logic op_valid;

	localparam int MSB = `CSF_DATA_W - 1;
	localparam int NMSB = `CSF_NIB_W - 1;

	////////////////////////////////////////////////////////////////
	csf_alu_flags u_alu
	(
		.req (alu_req),
		.res (res)
	);

	csf_sys_flags u_sys
	(
		.sys_clk (sys_clk),
		.reset (reset),
		.wdt_kick (wdt_kick),
		.halt_exec (halt_exec),
		.wdt_expire (wdt_expire),
		.watchdog_expired_flag_r (watchdog_expired_flag_r),
		.powerdown_flag_r (powerdown_flag_r)
	);

	assign op_valid = alu_req.valid;

	////////////////////////////////////////////////////////////////
	// Carry flag; operation result takes priority over a software write
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			carry_flag_r <= 1'b0;
		else if (op_valid && res.c_upd)
			carry_flag_r <= res.c;
		else if (sw_wr)
			carry_flag_r <= sw_wdata[`CSF_BIT_C];
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			half_carry_flag_r <= 1'b0;
			overflow_flag_r <= 1'b0;
			signed_compare_flag_r <= 1'b0;
		end
		else if (op_valid && res.arith_upd)
		begin
			half_carry_flag_r <= res.ac;
			overflow_flag_r <= res.ov;
			signed_compare_flag_r <= res.sc;
		end
		else if (sw_wr)
		begin
			half_carry_flag_r <= sw_wdata[`CSF_BIT_AC];
			overflow_flag_r <= sw_wdata[`CSF_BIT_OV];
			signed_compare_flag_r <= sw_wdata[`CSF_BIT_SC];
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			zero_flag_r <= 1'b0;
		else if (op_valid && res.z_upd)
			zero_flag_r <= res.z;
		else if (sw_wr)
			zero_flag_r <= sw_wdata[`CSF_BIT_Z];
	end

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		chained_zero_flag_nxt = chained_zero_flag_r;
		if (op_valid)
		begin
			unique case (alu_req.op)
				CSF_OP_SUB: chained_zero_flag_nxt = res.z;
				CSF_OP_SBC: chained_zero_flag_nxt = chained_zero_flag_r & res.z;
				CSF_OP_NONE, CSF_OP_ADD, CSF_OP_LOGIC, CSF_OP_RLC, CSF_OP_RRC:
					chained_zero_flag_nxt = chained_zero_flag_r;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			chained_zero_flag_r <= 1'b0;
		else if (op_valid && (alu_req.op == CSF_OP_SUB || alu_req.op == CSF_OP_SBC))
			chained_zero_flag_r <= chained_zero_flag_nxt;
		else if (sw_wr)
			chained_zero_flag_r <= sw_wdata[`CSF_BIT_CZ];
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			alu_result_r <= `CSF_ZERO_BYTE;
		else if (op_valid)
			alu_result_r <= res.result;
	end

	////////////////////////////////////////////////////////////////
	// No stack path exists; callers must save this value themselves
	always_comb
	begin
		arith_status_flags = `CSF_ZERO_BYTE;
		arith_status_flags[`CSF_BIT_C] = carry_flag_r;
		arith_status_flags[`CSF_BIT_AC] = half_carry_flag_r;
		arith_status_flags[`CSF_BIT_Z] = zero_flag_r;
		arith_status_flags[`CSF_BIT_OV] = overflow_flag_r;
		arith_status_flags[`CSF_BIT_PDF] = powerdown_flag_r;
		arith_status_flags[`CSF_BIT_TO] = watchdog_expired_flag_r;
		arith_status_flags[`CSF_BIT_CZ] = chained_zero_flag_r;
		arith_status_flags[`CSF_BIT_SC] = signed_compare_flag_r;
	end

	////////////////////////////////////////////////////////////////
	property p_sub_cz;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && alu_req.op == CSF_OP_SUB) |=> (chained_zero_flag_r == zero_flag_r);
	endproperty
	a_sub_cz: assert property (p_sub_cz) else $error("chained-zero differs from zero after sub");

	property p_sbc_cz;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && alu_req.op == CSF_OP_SBC) |=> (chained_zero_flag_r == ($past(chained_zero_flag_r) & zero_flag_r));
	endproperty
	a_sbc_cz: assert property (p_sbc_cz) else $error("chained-zero not anded after sbc");

	property p_other_cz;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && alu_req.op != CSF_OP_SUB && alu_req.op != CSF_OP_SBC && !sw_wr) |=> $stable(chained_zero_flag_r);
	endproperty
	a_other_cz: assert property (p_other_cz) else $error("chained-zero changed by other op");

	property p_zero;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && res.z_upd) |=> (zero_flag_r == (alu_result_r == `CSF_ZERO_BYTE));
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag does not match result");

	property p_sc;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && res.arith_upd) |=> (signed_compare_flag_r == (overflow_flag_r ^ alu_result_r[7]));
	endproperty
	a_sc: assert property (p_sc) else $error("signed-compare not ov xor msb");

	property p_carry_add;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && alu_req.op == CSF_OP_ADD) |=>
			(carry_flag_r == (({1'b0, $past(alu_req.a)} + {1'b0, $past(alu_req.b)} + {8'h00, $past(alu_req.carry_in)}) > 9'h0ff));
	endproperty
	a_carry_add: assert property (p_carry_add) else $error("carry wrong after add");

	property p_sw_sys;
		@(posedge sys_clk) disable iff (reset)
		(sw_wr && !wdt_kick && !halt_exec && !wdt_expire) |=> $stable(arith_status_flags[5:4]);
	endproperty
	a_sw_sys: assert property (p_sw_sys) else $error("software write changed system flags");

	property p_prio;
		@(posedge sys_clk) disable iff (reset)
		(sw_wr && op_valid && res.c_upd) |=> (carry_flag_r == $past(res.c));
	endproperty
	a_prio: assert property (p_prio) else $error("software write beat operation result");

	////////////////////////////////////////////////////////////////
	// Reference arithmetic kept apart from the flag adder, except sbc carry and add half carry, which repeat its sums
	property p_carry_sub;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && alu_req.op == CSF_OP_SUB) |=> (carry_flag_r == ($past(alu_req.a) >= $past(alu_req.b)));
	endproperty
	a_carry_sub: assert property (p_carry_sub) else $error("carry wrong after sub");

	property p_carry_sbc;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && alu_req.op == CSF_OP_SBC) |=> (carry_flag_r ==
			(({1'b0, $past(alu_req.a)} + {1'b0, ~$past(alu_req.b)} + {8'h00, $past(alu_req.carry_in)}) > 9'h0ff));
	endproperty
	a_carry_sbc: assert property (p_carry_sbc) else $error("carry wrong after subtract with borrow");

	property p_carry_rlc;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && alu_req.op == CSF_OP_RLC) |=> (carry_flag_r == $past(alu_req.a[MSB]));
	endproperty
	a_carry_rlc: assert property (p_carry_rlc) else $error("carry wrong after rotate left");

	property p_carry_rrc;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && alu_req.op == CSF_OP_RRC) |=> (carry_flag_r == $past(alu_req.a[0]));
	endproperty
	a_carry_rrc: assert property (p_carry_rrc) else $error("carry wrong after rotate right");

	property p_rlc_result;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && alu_req.op == CSF_OP_RLC) |=> (alu_result_r == {$past(alu_req.a[MSB-1:0]), $past(alu_req.carry_in)});
	endproperty
	a_rlc_result: assert property (p_rlc_result) else $error("rotate left result wrong");

	property p_rrc_result;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && alu_req.op == CSF_OP_RRC) |=> (alu_result_r == {$past(alu_req.carry_in), $past(alu_req.a[MSB:1])});
	endproperty
	a_rrc_result: assert property (p_rrc_result) else $error("rotate right result wrong");

	property p_rot_keep;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && (alu_req.op == CSF_OP_RLC || alu_req.op == CSF_OP_RRC) && !sw_wr) |=>
			($stable(zero_flag_r) && $stable(half_carry_flag_r) && $stable(overflow_flag_r) && $stable(signed_compare_flag_r));
	endproperty
	a_rot_keep: assert property (p_rot_keep) else $error("rotate changed a flag other than carry");

	property p_logic_keep;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && alu_req.op == CSF_OP_LOGIC && !sw_wr) |=>
			($stable(carry_flag_r) && $stable(half_carry_flag_r) && $stable(overflow_flag_r) && $stable(signed_compare_flag_r));
	endproperty
	a_logic_keep: assert property (p_logic_keep) else $error("logic op changed a flag other than zero");

	property p_ac_add;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && alu_req.op == CSF_OP_ADD) |=> (half_carry_flag_r ==
			(({1'b0, $past(alu_req.a[NMSB:0])} + {1'b0, $past(alu_req.b[NMSB:0])} + {4'h0, $past(alu_req.carry_in)}) > 5'h0f));
	endproperty
	a_ac_add: assert property (p_ac_add) else $error("half carry wrong after add");

	property p_ac_sub;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && alu_req.op == CSF_OP_SUB) |=> (half_carry_flag_r == ($past(alu_req.a[NMSB:0]) >= $past(alu_req.b[NMSB:0])));
	endproperty
	a_ac_sub: assert property (p_ac_sub) else $error("half carry wrong after sub");

	property p_ov_add;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && alu_req.op == CSF_OP_ADD) |=> (overflow_flag_r ==
			(($past(alu_req.a[MSB]) == $past(alu_req.b[MSB])) && (alu_result_r[MSB] != $past(alu_req.a[MSB]))));
	endproperty
	a_ov_add: assert property (p_ov_add) else $error("overflow wrong after add");

	property p_ov_sub;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && (alu_req.op == CSF_OP_SUB || alu_req.op == CSF_OP_SBC)) |=> (overflow_flag_r ==
			(($past(alu_req.a[MSB]) != $past(alu_req.b[MSB])) && (alu_result_r[MSB] != $past(alu_req.a[MSB]))));
	endproperty
	a_ov_sub: assert property (p_ov_sub) else $error("overflow wrong after subtract");

	property p_zero_sub;
		@(posedge sys_clk) disable iff (reset)
		(op_valid && alu_req.op == CSF_OP_SUB) |=> (zero_flag_r == ($past(alu_req.a) == $past(alu_req.b)));
	endproperty
	a_zero_sub: assert property (p_zero_sub) else $error("zero flag wrong after sub");

	property p_sw_write;
		@(posedge sys_clk) disable iff (reset)
		(sw_wr && !op_valid) |=> (carry_flag_r == $past(sw_wdata[`CSF_BIT_C])
			&& half_carry_flag_r == $past(sw_wdata[`CSF_BIT_AC]) && zero_flag_r == $past(sw_wdata[`CSF_BIT_Z])
			&& overflow_flag_r == $past(sw_wdata[`CSF_BIT_OV]) && chained_zero_flag_r == $past(sw_wdata[`CSF_BIT_CZ])
			&& signed_compare_flag_r == $past(sw_wdata[`CSF_BIT_SC]));
	endproperty
	a_sw_write: assert property (p_sw_write) else $error("software write did not land in arithmetic flags");

	property p_flags_idle;
		@(posedge sys_clk) disable iff (reset)
		(!op_valid && !sw_wr) |=>
			($stable(arith_status_flags[`CSF_BIT_OV:`CSF_BIT_C]) && $stable(arith_status_flags[`CSF_BIT_SC:`CSF_BIT_CZ]));
	endproperty
	a_flags_idle: assert property (p_flags_idle) else $error("arithmetic flag changed with no operation");

	property p_pdf_hold;
		@(posedge sys_clk) disable iff (reset)
		(!wdt_kick && !halt_exec) |=> $stable(powerdown_flag_r);
	endproperty
	a_pdf_hold: assert property (p_pdf_hold) else $error("power-down flag changed without event");

	// Deliberately not disabled by reset: this one watches the reset itself
	property p_reset_flags;
		@(posedge sys_clk)
		reset |=> (arith_status_flags == `CSF_ZERO_BYTE);
	endproperty
	a_reset_flags: assert property (p_reset_flags) else $error("status not cleared by power-up");
endmodule

// ### bench/csf_exec_model.sv
// Model of the execution unit that issues operations and system events
`timescale 1ns/10ps
module csf_exec_model
(
	input wire logic sys_clk, // Core clock
	output csf_pkg::csf_alu_req_t alu_req, // Operation to the flag unit
	output logic wdt_kick, // Clear-watchdog executed
	output logic halt_exec, // Halt executed
	output logic wdt_expire // Watchdog timer expiry
);
	import csf_pkg::*;
	initial
	begin
		alu_req = '0;
		{wdt_kick, halt_exec, wdt_expire} = 3'h0;
	end
	////////////////////////////////////////////////////////////////
	// Called at a falling edge; request and events stand for one rising edge only
	task automatic issue(input csf_op_t op, input logic [7:0] a, input logic [7:0] b, input logic cin,
		input logic [2:0] ev);
		alu_req <= '{valid: op != CSF_OP_NONE, op: op, a: a, b: b, carry_in: cin};
		{wdt_kick, halt_exec, wdt_expire} <= ev;
		@(negedge sys_clk);
		// Operands are scrambled once the request drops, so stale values cannot pass
		alu_req <= '{valid: 1'b0, op: CSF_OP_NONE, a: ~a, b: ~b, carry_in: ~cin};
		{wdt_kick, halt_exec, wdt_expire} <= 3'h0;
	endtask
endmodule

// ### bench/csf_status_unit_bench.sv
// Self-checking bench for the status flag unit
`timescale 1ns/10ps
module csf_status_unit_bench;
	import csf_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic sw_wr = 1'b0;
	logic [7:0] sw_wdata = 8'h00;
	csf_alu_req_t alu_req;
	logic wdt_kick;
	logic halt_exec;
	logic wdt_expire;
	logic [7:0] alu_result_r;
	logic [7:0] arith_status_flags;
	logic [7:0] exp_f = 8'h00;
	logic [7:0] exp_r = 8'h00;
	int bad_count = 0;
	int cmp_count = 0;
	always #2 sys_clk = ~sys_clk;
	csf_exec_model exec_u (.sys_clk(sys_clk), .alu_req(alu_req), .wdt_kick(wdt_kick),
		.halt_exec(halt_exec), .wdt_expire(wdt_expire));
	csf_status_unit dut_u (.sys_clk(sys_clk), .reset(reset), .alu_req(alu_req), .sw_wr(sw_wr),
		.sw_wdata(sw_wdata), .wdt_kick(wdt_kick), .halt_exec(halt_exec), .wdt_expire(wdt_expire),
		.alu_result_r(alu_result_r), .arith_status_flags(arith_status_flags));
	////////////////////////////////////////////////////////////////
	task automatic chk_flags(input logic [7:0] got);
		cmp_count++;
		if (got !== exp_f)
		begin
			bad_count++;
			$display("Error at %0t: flags %h, expected %h", $time, got, exp_f);
		end
	endtask
	task automatic chk_result(input logic [7:0] got);
		cmp_count++;
		if (got !== exp_r)
		begin
			bad_count++;
			$display("Error at %0t: result %h, expected %h", $time, got, exp_r);
		end
	endtask
	// Events: ev = {kick, halt, expiry}; carry in of subtract-with-borrow and rotates is the current carry
	task automatic step(input csf_op_t op, input logic [7:0] a, input logic [7:0] b, input logic [2:0] ev,
		input logic wr, input logic [7:0] wd);
		logic [8:0] s;
		logic [4:0] n;
		logic [7:0] m;
		logic [7:0] bb;
		logic cin;
		logic ov;
		logic cz;
		cin = (op == CSF_OP_ADD) ? 1'b0 : (op == CSF_OP_SUB) ? 1'b1 : exp_f[0];
		bb = (op == CSF_OP_ADD) ? b : ~b;
		@(negedge sys_clk);
		cz = exp_f[6];
		if (wr)
			exp_f = {wd[7:6], exp_f[5:4], wd[3:0]};
		s = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
		n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
		m = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, cin};
		ov = m[7] ^ s[8];
		case (op)
			CSF_OP_ADD, CSF_OP_SUB, CSF_OP_SBC:
			begin
				exp_r = s[7:0];
				exp_f[3:0] = {ov, exp_r == 8'h00, n[4], s[8]};
				exp_f[7] = ov ^ exp_r[7];
				if (op == CSF_OP_SUB)
					exp_f[6] = exp_f[2];
				if (op == CSF_OP_SBC)
					exp_f[6] = cz & exp_f[2];
			end
			CSF_OP_LOGIC:
			begin
				exp_r = a;
				exp_f[2] = a == 8'h00;
			end
			CSF_OP_RLC:
			begin
				exp_r = {a[6:0], cin};
				exp_f[0] = a[7];
			end
			CSF_OP_RRC:
			begin
				exp_r = {cin, a[7:1]};
				exp_f[0] = a[0];
			end
			default:;
		endcase
		if (ev[2])
			exp_f[5:4] = 2'b00;
		if (ev[1])
			exp_f[5:4] = 2'b01;
		if (ev[0])
			exp_f[5] = 1'b1;
		sw_wr <= wr;
		sw_wdata <= wd;
		exec_u.issue(op, a, b, cin, ev);
		sw_wr <= 1'b0;
		sw_wdata <= ~wd;
		chk_flags(arith_status_flags);
		if (op != CSF_OP_NONE)
			chk_result(alu_result_r);
	endtask
	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Whole run needs about 70 cycles; this leaves ample margin
	initial
	begin
		#20000;
		bad_count++;
		$display("Error at %0t: watchdog expired", $time);
		tally_and_finish();
	end
	initial
	begin
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
		reset = 1'b0;
		chk_flags(arith_status_flags);
		$display("Test reset done");
		step(CSF_OP_ADD, 8'h7f, 8'h01, 3'h0, 1'b0, 8'h00);
		step(CSF_OP_ADD, 8'hff, 8'h01, 3'h0, 1'b0, 8'h00);
		step(CSF_OP_ADD, 8'h80, 8'h80, 3'h0, 1'b0, 8'h00);
		step(CSF_OP_ADD, 8'h0f, 8'h01, 3'h0, 1'b0, 8'h00);
		$display("Test add done");
		step(CSF_OP_SUB, 8'h05, 8'h05, 3'h0, 1'b0, 8'h00);
		step(CSF_OP_SBC, 8'h03, 8'h03, 3'h0, 1'b0, 8'h00);
		step(CSF_OP_SBC, 8'h03, 8'h01, 3'h0, 1'b0, 8'h00);
		step(CSF_OP_SBC, 8'h00, 8'h00, 3'h0, 1'b0, 8'h00);
		step(CSF_OP_SUB, 8'h00, 8'h01, 3'h0, 1'b0, 8'h00);
		step(CSF_OP_SUB, 8'h80, 8'h01, 3'h0, 1'b0, 8'h00);
		step(CSF_OP_SUB, 8'h10, 8'h10, 3'h0, 1'b0, 8'h00);
		step(CSF_OP_LOGIC, 8'h5a, 8'h00, 3'h0, 1'b0, 8'h00);
		step(CSF_OP_ADD, 8'h00, 8'h00, 3'h0, 1'b0, 8'h00);
		step(CSF_OP_LOGIC, 8'h00, 8'h00, 3'h0, 1'b0, 8'h00);
		$display("Test subtract done");
		step(CSF_OP_RLC, 8'h81, 8'h00, 3'h0, 1'b0, 8'h00);
		step(CSF_OP_RRC, 8'h02, 8'h00, 3'h0, 1'b0, 8'h00);
		step(CSF_OP_RRC, 8'h01, 8'h00, 3'h0, 1'b0, 8'h00);
		$display("Test rotate done");
		step(CSF_OP_NONE, 8'h00, 8'h00, 3'h0, 1'b1, 8'hff);
		step(CSF_OP_ADD, 8'h01, 8'h01, 3'h0, 1'b1, 8'hff);
		step(CSF_OP_SUB, 8'h02, 8'h01, 3'h0, 1'b1, 8'h44);
		step(CSF_OP_SBC, 8'h08, 8'h08, 3'h0, 1'b1, 8'h40);
		$display("Test write done");
		step(CSF_OP_NONE, 8'h00, 8'h00, 3'h2, 1'b0, 8'h00);
		step(CSF_OP_NONE, 8'h00, 8'h00, 3'h1, 1'b0, 8'h00);
		step(CSF_OP_NONE, 8'h00, 8'h00, 3'h0, 1'b1, 8'h00);
		step(CSF_OP_NONE, 8'h00, 8'h00, 3'h4, 1'b0, 8'h00);
		step(CSF_OP_NONE, 8'h00, 8'h00, 3'h0, 1'b1, 8'hff);
		step(CSF_OP_NONE, 8'h00, 8'h00, 3'h3, 1'b0, 8'h00);
		step(CSF_OP_ADD, 8'h01, 8'h02, 3'h6, 1'b0, 8'h00);
		$display("Test events done");
		tally_and_finish();
	end
endmodule
